// ===== hdl/sfes_device.sv
// Purpose: device end, decodes erase frames and runs timed erases
// Assumes: link lines sampled by the core clock, 2 flops on data, 3 on clock and select
// Notes:   protection granularity is one 64K block
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module sfes_device import sfes_pkg::*; #(
   parameter int NBLK       = 16,
   parameter int SECTOR_CYC = 400,
   parameter int HALF_CYC   = 800,
   parameter int FULL_CYC   = 1200,
   parameter int WHOLE_CYC  = 3000
) (
   // clock and reset
   input  wire logic            i_core_clk,
   input  wire logic            i_rst,
   // link
   sfes_link_if.device          link,
   // configuration and protection
   input  wire logic            i_quad_mode,
   input  wire logic            i_quad_enable,
   input  wire logic            i_extended_address_bit,
   input  wire logic            i_protect_select,
   input  wire logic [3:0]      i_block_protect,
   input  wire logic [NBLK-1:0] i_persistent_sector_protect,
   input  wire logic [NBLK-1:0] i_dynamic_sector_protect,
   input  wire logic [31:0]     i_boot_config,
   // array side
   input  wire logic [7:0]      i_read_data,
   output logic [31:0]          o_read_addr,
   output logic                 o_erase_busy,
   output logic                 o_erase_done,
   output sfes_erase_t          o_erase_kind,
   output logic [31:0]          o_erase_base,
   output logic [NBLK-1:0]      o_erase_skip,
   output logic                 o_write_enable_latch,
   output logic                 o_four_byte
);
   localparam int BLK_W = $clog2(NBLK);
   typedef enum {L_IDLE, L_BOOT, L_CMD, L_STATUS} sfes_lstate_t;
   sfes_lstate_t state;
   logic [3:0]   sio_m, sio_s;
   logic         sclk_m, sclk_s, sclk_q, cs_m, cs_s, cs_q;
   logic         rise, fall, cs_fall, cs_rise;
   logic [5:0]   cnt, next_cnt, addr_end, boot_delay;
   logic [39:0]  sr, next_sr;
   logic [7:0]   opc, tx, src;
   logic [2:0]   ob;
   logic         oq, boot_armed, boot_taken;
   logic [31:0]  boot_addr, addr, ecnt;
   logic [BLK_W-1:0] tblk;
   logic [BLK_W:0]   bp_span;
   logic         prot, frame_ok;

   // =======================================================
   // link sampling
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sio_m <= 4'hf; sio_s <= 4'hf;
         sclk_m <= 1'b0; sclk_s <= 1'b0; sclk_q <= 1'b0;
         cs_m <= 1'b1; cs_s <= 1'b1; cs_q <= 1'b1;
      end else begin
         sio_m <= link.sio; sio_s <= sio_m;
         sclk_m <= link.sclk; sclk_s <= sclk_m; sclk_q <= sclk_s;
         cs_m <= link.cs_n; cs_s <= cs_m; cs_q <= cs_s;
      end
   end
   assign rise    = sclk_s & ~sclk_q & ~cs_s;
   assign fall    = ~sclk_s & sclk_q & ~cs_s;
   assign cs_fall = ~cs_s & cs_q;
   assign cs_rise = cs_s & ~cs_q;

   // =======================================================
   // decode helpers
   always_comb begin
      // upper lines ignored in single-line mode
      next_sr  = i_quad_mode ? {sr[35:0], sio_s} : {sr[38:0], sio_s[0]};
      next_cnt = (cnt > 6'd59) ? CNT_SAT : cnt + (i_quad_mode ? 6'd4 : 6'd1);
      addr_end = (o_four_byte | i_extended_address_bit) ? 6'd40 : 6'd32;
      addr     = (o_four_byte | i_extended_address_bit) ? sr[31:0] : {8'h00, sr[23:0]};
      tblk     = addr[FULL_BLOCK_SHIFT +: BLK_W];
      bp_span  = '0;
      if (i_block_protect != 4'h0)
         bp_span = (32'(i_block_protect) - 32'd1 >= 32'(BLK_W)) ? (BLK_W+1)'(NBLK)
                   : (BLK_W+1)'(1) << (i_block_protect - 4'h1);
      prot = i_protect_select
             ? (i_persistent_sector_protect[tblk] | i_dynamic_sector_protect[tblk])
             : ({1'b0, tblk} >= (BLK_W+1)'(NBLK) - bp_span);
      frame_ok = cs_rise && state == L_CMD && !o_erase_busy && o_write_enable_latch;
      oq  = (state == L_BOOT) ? i_quad_enable : i_quad_mode;
      src = (state == L_BOOT) ? i_read_data
            : {6'h00, o_write_enable_latch, o_erase_busy};
   end

   // =======================================================
   // boot configuration caught after reset release
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         boot_taken <= 1'b0;
         boot_armed <= 1'b0;
         boot_delay <= '0;
         boot_addr  <= '0;
      end else if (!boot_taken) begin
         boot_taken <= 1'b1;
         boot_armed <= ~i_boot_config[BOOT_EN_N_BIT];
         boot_delay <= BOOT_DELAY_BASE
                     + {3'b000, i_boot_config[BOOT_DELAY_LSB +: 2], 1'b0};
         boot_addr  <= {i_boot_config[31:BOOT_ADDR_LSB], 4'h0};
      end else if (cs_rise && state == L_BOOT) begin
         boot_armed <= 1'b0;
      end
   end

   // =======================================================
   // link frame handling
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state <= L_IDLE;
         cnt <= '0; sr <= '0; opc <= '0; tx <= '0; ob <= '0;
         o_read_addr  <= '0;
         link.dev_out <= '0;
         link.dev_oe  <= '0;
      end else if (cs_rise) begin
         state       <= L_IDLE;
         link.dev_oe <= '0;
      end else if (cs_fall) begin
         cnt   <= '0;
         ob    <= '0;
         state <= boot_armed ? L_BOOT : L_CMD;
         o_read_addr <= boot_addr;
      end else begin
         unique case (state)
            L_IDLE: ;
            L_CMD: if (rise) begin
               sr  <= next_sr;
               cnt <= next_cnt;
               if (next_cnt == OPCODE_BITS) begin
                  opc <= next_sr[7:0];
                  if (next_sr[7:0] == OP_READ_STATUS)
                     state <= L_STATUS;
               end
            end
            L_BOOT: if (rise && cnt != CNT_SAT) begin
               cnt <= cnt + 6'd1;
            end
            L_STATUS: ;
         endcase
         // last delay clock index is delay minus one
         if (fall && (state == L_STATUS || (state == L_BOOT && cnt >= boot_delay))) begin
            link.dev_oe <= oq ? 4'hf : 4'h2;
            if (ob == '0) begin
               link.dev_out <= oq ? src[7:4] : {2'b00, src[7], 1'b0};
               tx <= oq ? {src[3:0], 4'h0} : {src[6:0], 1'b0};
               ob <= oq ? 3'd1 : 3'd7;
               if (state == L_BOOT)
                  o_read_addr <= o_read_addr + 32'd1;
            end else begin
               link.dev_out <= oq ? tx[7:4] : {2'b00, tx[7], 1'b0};
               tx <= oq ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
               ob <= ob - 3'd1;
            end
         end
      end
   end

   // =======================================================
   // latches and self-timed erase
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         o_write_enable_latch <= 1'b0;
         o_four_byte  <= 1'b0;
         o_erase_busy <= 1'b0;
         o_erase_done <= 1'b0;
         o_erase_kind <= ERASE_SECTOR;
         o_erase_base <= '0;
         o_erase_skip <= '0;
         ecnt         <= '0;
      end else begin
         o_erase_done <= 1'b0;
         if (o_erase_busy) begin
            ecnt <= ecnt - 32'd1;
            if (ecnt == 32'd1) begin
               o_erase_busy         <= 1'b0;
               o_write_enable_latch <= 1'b0;
               o_erase_done         <= 1'b1;
            end
         end else if (cs_rise && state == L_CMD && cnt == OPCODE_BITS) begin
            if (opc == OP_WRITE_ENABLE)
               o_write_enable_latch <= 1'b1;
            if (opc == OP_ENTER_FOUR_BYTE)
               o_four_byte <= 1'b1;
         end
         // exact frame length only, else rejected
         if (frame_ok && cnt == addr_end && !prot) begin
            o_erase_skip <= '0;
            if (opc == OP_SECTOR_ERASE) begin
               o_erase_busy <= 1'b1;
               o_erase_kind <= ERASE_SECTOR;
               o_erase_base <= (addr >> SECTOR_SHIFT) << SECTOR_SHIFT;
               ecnt         <= 32'(SECTOR_CYC);
            end else if (opc == OP_HALF_BLOCK_ERASE) begin
               o_erase_busy <= 1'b1;
               o_erase_kind <= ERASE_HALF;
               o_erase_base <= (addr >> HALF_BLOCK_SHIFT) << HALF_BLOCK_SHIFT;
               ecnt         <= 32'(HALF_CYC);
            end else if (opc == OP_FULL_BLOCK_ERASE) begin
               o_erase_busy <= 1'b1;
               o_erase_kind <= ERASE_FULL;
               o_erase_base <= (addr >> FULL_BLOCK_SHIFT) << FULL_BLOCK_SHIFT;
               ecnt         <= 32'(FULL_CYC);
            end
         end
         if (frame_ok && cnt == OPCODE_BITS && opc == OP_WHOLE_ARRAY_ERASE
             && (i_protect_select || i_block_protect == 4'h0)) begin
            o_erase_busy <= 1'b1;
            o_erase_kind <= ERASE_WHOLE;
            o_erase_base <= '0;
            o_erase_skip <= i_protect_select
                          ? (i_persistent_sector_protect | i_dynamic_sector_protect)
                          : '0;
            ecnt         <= 32'(WHOLE_CYC);
         end
      end
   end
endmodule : sfes_device

// ===== hdl/sfes_pkg.sv
// Purpose: shared constants and types for the serial flash erase link
// Assumes: both ends import this package
// Notes:   erase times are module parameters in core clock cycles
package sfes_pkg;
   // =======================================================
   // opcodes
   localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
   localparam logic [7:0] OP_SECTOR_ERASE      = 8'h20;
   localparam logic [7:0] OP_HALF_BLOCK_ERASE  = 8'h52;
   localparam logic [7:0] OP_FULL_BLOCK_ERASE  = 8'hd8;
   localparam logic [7:0] OP_WHOLE_ARRAY_ERASE = 8'h60;
   localparam logic [7:0] OP_ENTER_FOUR_BYTE   = 8'hb7;
   localparam logic [7:0] OP_READ_STATUS       = 8'h05;
   // =======================================================
   // field positions and reset values
   localparam int          SECTOR_SHIFT     = 12;
   localparam int          HALF_BLOCK_SHIFT = 15;
   localparam int          FULL_BLOCK_SHIFT = 16;
   localparam int          STATUS_WIP_BIT   = 0;
   localparam int          STATUS_WEL_BIT   = 1;
   localparam int          BOOT_EN_N_BIT    = 0;
   localparam int          BOOT_DELAY_LSB   = 1;
   localparam int          BOOT_ADDR_LSB    = 4;
   localparam logic [31:0] BOOT_CFG_RESET   = 32'hffff_ffff;
   localparam logic [5:0]  BOOT_DELAY_BASE  = 6'h07;
   localparam logic [5:0]  OPCODE_BITS      = 6'h08;
   localparam logic [5:0]  CNT_SAT          = 6'h3f;
   localparam logic [7:0]  HOST_GAP_CYC     = 8'h08;
   // =======================================================
   // types
   typedef enum logic [2:0] {
      KIND_WRITE_ENABLE, KIND_SECTOR, KIND_HALF, KIND_FULL,
      KIND_WHOLE, KIND_FOUR_BYTE, KIND_STATUS, KIND_BOOT
   } sfes_kind_t;
   typedef enum logic [1:0] {
      ERASE_SECTOR, ERASE_HALF, ERASE_FULL, ERASE_WHOLE
   } sfes_erase_t;
endpackage : sfes_pkg

// ===== hdl/sfes_link_if.sv
// Purpose: serial/quad flash link between host and device
// Assumes: pulled-up data lines when nobody drives them
// Notes:   wire levels are resolved here from both enables
`timescale 1ns/1ns
interface sfes_link_if;
   logic       sclk;
   logic       cs_n;
   logic [3:0] host_out;
   logic [3:0] host_oe;
   logic [3:0] dev_out;
   logic [3:0] dev_oe;
   logic [3:0] sio;
   assign sio = (dev_out & dev_oe) | (host_out & host_oe) | ~(dev_oe | host_oe);
   modport host   (output sclk, cs_n, host_out, host_oe, input sio);
   modport device (input sclk, cs_n, sio, output dev_out, dev_oe);
endinterface : sfes_link_if

// ===== hdl/sfes_host.sv
// Purpose: host end, sends erase, enable, status and boot read frames
// Assumes: link clock made here by a divider of the core clock
// Notes:   erase requests get a write-enable frame sent first
`timescale 1ns/1ns
module sfes_host import sfes_pkg::*; #(
   parameter int HALF_PERIOD = 8
) (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // link
   sfes_link_if.host       link,
   // command
   input  wire logic       i_cmd_valid,
   input  sfes_kind_t      i_cmd_kind,
   input  wire logic [31:0] i_cmd_addr,
   input  wire logic       i_quad_mode,
   input  wire logic       i_four_byte,
   input  wire logic [5:0] i_boot_delay,
   input  wire logic       i_boot_quad,
   // answer
   output logic            o_ready,
   output logic            o_done,
   output logic [7:0]      o_rx_data
);
   typedef enum {H_IDLE, H_LOAD, H_RUN, H_GAP} sfes_hstate_t;
   sfes_hstate_t state;
   sfes_kind_t   kind, fk;
   logic [31:0]  addr;
   logic [39:0]  tx, f_tx;
   logic [7:0]   rx, div, op;
   logic [5:0]   cidx, total, txc, rxfrom, f_total, f_txc, f_rxfrom, f_bits;
   logic         rxq, f_rxq;
   logic [3:0]   sio_m, sio_s;

   // =======================================================
   // frame shape from frame kind
   always_comb begin
      op       = OP_WRITE_ENABLE;
      f_bits   = OPCODE_BITS;
      f_rxfrom = CNT_SAT;
      f_rxq    = i_quad_mode;
      unique case (fk)
         KIND_WRITE_ENABLE: op = OP_WRITE_ENABLE;
         KIND_SECTOR:       op = OP_SECTOR_ERASE;
         KIND_HALF:         op = OP_HALF_BLOCK_ERASE;
         KIND_FULL:         op = OP_FULL_BLOCK_ERASE;
         KIND_WHOLE:        op = OP_WHOLE_ARRAY_ERASE;
         KIND_FOUR_BYTE:    op = OP_ENTER_FOUR_BYTE;
         KIND_STATUS:       op = OP_READ_STATUS;
         KIND_BOOT:         op = OP_READ_STATUS;
      endcase
      if (fk inside {KIND_SECTOR, KIND_HALF, KIND_FULL})
         f_bits = i_four_byte ? 6'd40 : 6'd32;
      f_tx  = i_four_byte ? {op, addr} : {op, addr[23:0], 8'h00};
      f_txc = i_quad_mode ? (f_bits >> 2) : f_bits;
      f_total = f_txc;
      if (fk == KIND_STATUS) begin
         f_rxfrom = f_txc;
         f_total  = f_txc + f_txc;
      end else if (fk == KIND_BOOT) begin
         f_txc    = '0;
         f_rxfrom = i_boot_delay;
         f_rxq    = i_boot_quad;
         f_total  = i_boot_delay + (i_boot_quad ? 6'd2 : 6'd8);
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         sio_m <= 4'hf;
         sio_s <= 4'hf;
      end else begin
         sio_m <= link.sio;
         sio_s <= sio_m;
      end
   end

   // =======================================================
   // sequencer
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state         <= H_IDLE;
         kind          <= KIND_STATUS;
         fk            <= KIND_STATUS;
         addr          <= '0;
         link.sclk     <= 1'b0;
         link.cs_n     <= 1'b1;
         link.host_out <= '0;
         link.host_oe  <= '0;
         tx <= '0; rx <= '0; div <= '0; cidx <= '0;
         total <= '0; txc <= '0; rxfrom <= '0; rxq <= 1'b0;
         o_ready <= 1'b1; o_done <= 1'b0; o_rx_data <= '0;
      end else begin
         o_done <= 1'b0;
         unique case (state)
            H_IDLE: if (i_cmd_valid) begin
               kind    <= i_cmd_kind;
               addr    <= i_cmd_addr;
               o_ready <= 1'b0;
               state   <= H_LOAD;
               // erase needs the latch set first
               fk <= (i_cmd_kind inside {KIND_SECTOR, KIND_HALF, KIND_FULL, KIND_WHOLE})
                     ? KIND_WRITE_ENABLE : i_cmd_kind;
            end
            H_LOAD: begin
               link.cs_n <= 1'b0;
               link.sclk <= 1'b0;
               total  <= f_total;
               txc    <= f_txc;
               rxfrom <= f_rxfrom;
               rxq    <= f_rxq;
               cidx   <= '0;
               div    <= 8'(HALF_PERIOD - 1);
               link.host_out <= i_quad_mode ? f_tx[39:36] : {3'b000, f_tx[39]};
               link.host_oe  <= (f_txc == '0) ? 4'h0 : (i_quad_mode ? 4'hf : 4'h1);
               tx    <= i_quad_mode ? {f_tx[35:0], 4'h0} : {f_tx[38:0], 1'b0};
               state <= H_RUN;
            end
            H_RUN: if (div != '0) begin
               div <= div - 8'h01;
            end else begin
               div <= 8'(HALF_PERIOD - 1);
               if (!link.sclk) begin
                  link.sclk <= 1'b1;
                  if (cidx >= rxfrom)
                     rx <= rxq ? {rx[3:0], sio_s} : {rx[6:0], sio_s[1]};
               end else begin
                  link.sclk <= 1'b0;
                  cidx      <= cidx + 6'd1;
                  if (cidx + 6'd1 == total) begin
                     link.cs_n    <= 1'b1;
                     link.host_oe <= '0;
                     div          <= HOST_GAP_CYC;
                     state        <= H_GAP;
                  end else if (cidx + 6'd1 < txc) begin
                     link.host_out <= i_quad_mode ? tx[39:36] : {3'b000, tx[39]};
                     tx <= i_quad_mode ? {tx[35:0], 4'h0} : {tx[38:0], 1'b0};
                  end else begin
                     link.host_oe <= '0;
                  end
               end
            end
            H_GAP: if (div != '0) begin
               div <= div - 8'h01;
            end else if (fk != kind) begin
               fk    <= kind;
               state <= H_LOAD;
            end else begin
               o_done    <= 1'b1;
               o_rx_data <= rx;
               o_ready   <= 1'b1;
               state     <= H_IDLE;
            end
         endcase
      end
   end
endmodule : sfes_host

// ===== tb/sfes_properties.sv
// Purpose: timing checks on the main link and erase status
// Assumes: one core clock domain, sync reset
// Notes:   watches the host-to-device link only
`timescale 1ns/1ns
module sfes_properties import sfes_pkg::*; #(
   parameter int SECTOR_CYC = 400,
   parameter int HALF_CYC   = 800,
   parameter int FULL_CYC   = 1200,
   parameter int WHOLE_CYC  = 3000
) (
   // clock and reset
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   // link
   input  wire logic       i_sclk,
   input  wire logic       i_cs_n,
   input  wire logic [3:0] i_host_oe,
   input  wire logic [3:0] i_dev_oe,
   // device status
   input  wire logic       i_erase_busy,
   input  wire logic       i_erase_done,
   input  sfes_erase_t     i_erase_kind,
   input  wire logic       i_write_enable_latch
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // ========
   // busy length counter
   int run_len;
   int exp_len;
   always_ff @(posedge i_core_clk) begin
      if (i_rst || !i_erase_busy)
         run_len <= 0;
      else
         run_len <= run_len + 1;
   end
   assign exp_len = (i_erase_kind == ERASE_SECTOR) ? SECTOR_CYC :
                    (i_erase_kind == ERASE_HALF) ? HALF_CYC :
                    (i_erase_kind == ERASE_FULL) ? FULL_CYC : WHOLE_CYC;
   // ========
   // properties
   property p_idle_sclk; i_cs_n |-> !i_sclk; endproperty
   a_idle_sclk: assert property (p_idle_sclk) else $error("link clock high while idle");
   property p_one_driver; (i_host_oe & i_dev_oe) == 4'h0; endproperty
   a_one_driver: assert property (p_one_driver) else $error("both ends drive a line");
   property p_dev_quiet; i_cs_n [*4] |-> i_dev_oe == 4'h0; endproperty
   a_dev_quiet: assert property (p_dev_quiet) else $error("device drives when deselected");
   property p_start; $rose(i_erase_busy) |-> i_cs_n && $past(i_cs_n, 3); endproperty
   a_start: assert property (p_start) else $error("erase began while selected");
   property p_need_latch; $rose(i_erase_busy) |-> $past(i_write_enable_latch); endproperty
   a_need_latch: assert property (p_need_latch) else $error("erase began without latch");
   property p_latch_kept; i_erase_busy |-> i_write_enable_latch; endproperty
   a_latch_kept: assert property (p_latch_kept) else $error("latch lost during erase");
   property p_done;
      i_erase_done |-> !i_erase_busy && !i_write_enable_latch && $past(i_erase_busy)
                       ##1 !i_erase_done;
   endproperty
   a_done: assert property (p_done) else $error("bad erase completion");
   property p_run_len; $fell(i_erase_busy) |-> run_len == exp_len; endproperty
   a_run_len: assert property (p_run_len) else $error("erase time wrong");
endmodule : sfes_properties

// ===== tb/tb_top.sv
// Purpose: host and device joined, erase, boot and refusal cases
// Assumes: second device is driven by bench bit-banging
// Notes:   array data is a fixed function of the read address
`timescale 1ns/1ns
module tb_top import sfes_pkg::*; ();
   logic clk, rst, cmd_valid, quad_mode, ext_addr, four_byte, psel, quad_en, boot_quad;
   logic busy, edone, write_enable_latch, fourb, ready, hdone, busy2, wel2;
   logic [31:0] cmd_addr, boot_cfg, rd_addr, base;
   logic [15:0] psp, dsp, skip;
   logic [7:0]  rx, rd_data;
   logic [5:0]  boot_delay;
   logic [3:0]  bprot;
   sfes_kind_t  cmd_kind;
   sfes_erase_t ekind;
   int          n_fail, samples_checked, seed;
   sfes_link_if link();
   sfes_link_if link2();
   assign rd_data = rd_addr[7:0] ^ 8'h5a;
   // ========
   // instances
   sfes_host i_sfes_host (.i_core_clk(clk), .i_rst(rst), .link(link.host),
      .i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind), .i_cmd_addr(cmd_addr),
      .i_quad_mode(quad_mode), .i_four_byte(four_byte), .i_boot_delay(boot_delay),
      .i_boot_quad(boot_quad), .o_ready(ready), .o_done(hdone), .o_rx_data(rx));
   sfes_device i_sfes_device (.i_core_clk(clk), .i_rst(rst), .link(link.device),
      .i_quad_mode(quad_mode), .i_quad_enable(quad_en), .i_extended_address_bit(ext_addr),
      .i_protect_select(psel), .i_block_protect(bprot), .i_persistent_sector_protect(psp),
      .i_dynamic_sector_protect(dsp), .i_boot_config(boot_cfg), .i_read_data(rd_data),
      .o_read_addr(rd_addr), .o_erase_busy(busy), .o_erase_done(edone), .o_erase_kind(ekind),
      .o_erase_base(base), .o_erase_skip(skip), .o_write_enable_latch(write_enable_latch),
      .o_four_byte(fourb));
   // rogue frames reach this one only
   sfes_device i_sfes_device_rogue (.i_core_clk(clk), .i_rst(rst), .link(link2.device),
      .i_quad_mode(quad_mode), .i_quad_enable(quad_en), .i_extended_address_bit(ext_addr),
      .i_protect_select(psel), .i_block_protect(bprot), .i_persistent_sector_protect(psp),
      .i_dynamic_sector_protect(dsp), .i_boot_config(boot_cfg), .i_read_data(8'h00),
      .o_read_addr(), .o_erase_busy(busy2), .o_erase_done(), .o_erase_kind(),
      .o_erase_base(), .o_erase_skip(), .o_write_enable_latch(wel2), .o_four_byte());
   sfes_properties #(.SECTOR_CYC(400), .HALF_CYC(800), .FULL_CYC(1200), .WHOLE_CYC(3000))
      i_sfes_properties (.i_core_clk(clk), .i_rst(rst), .i_sclk(link.sclk), .i_cs_n(link.cs_n),
      .i_host_oe(link.host_oe), .i_dev_oe(link.dev_oe), .i_erase_busy(busy),
      .i_erase_done(edone), .i_erase_kind(ekind), .i_write_enable_latch(write_enable_latch));
   // ========
   // tasks
   task automatic close_out;
      $display("checked %0d mismatched %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic limit(input int i);
      if (i >= 5000) begin
         n_fail++;
         close_out();
      end
   endtask : limit
   function automatic logic [31:0] exp_base(input sfes_kind_t k, input logic [31:0] a);
      int s;
      s = (k == KIND_SECTOR) ? 12 : (k == KIND_HALF) ? 15 : 16;
      return (a >> s) << s;
   endfunction : exp_base
   task automatic host_cmd(input sfes_kind_t k, input logic [31:0] a);
      int i;
      for (i = 0; i < 5000 && ready !== 1'b1; i++) tick(1);
      limit(i);
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_valid <= 1'b1;
      tick(1);
      cmd_valid <= 1'b0;
      for (i = 0; i < 5000 && hdone !== 1'b1; i++) tick(1);
      limit(i);
   endtask : host_cmd
   task automatic do_erase(input sfes_kind_t k, input logic [31:0] a, input logic run);
      int i;
      logic [31:0] m;
      m = four_byte ? a : {8'h00, a[23:0]};
      host_cmd(k, a);
      check(32'(busy), 32'(run));
      if (run) begin
         check(32'(ekind), 32'(k) - 32'd1);
         if (k != KIND_WHOLE)
            check(base, exp_base(k, m));
         else
            check(32'(skip), psel ? 32'(psp | dsp) : 32'h0);
         host_cmd(KIND_STATUS, 32'h0);
         check(32'(rx), 32'h3);
         for (i = 0; i < 5000 && busy !== 1'b0; i++) tick(1);
         limit(i);
         check(32'(write_enable_latch), 32'h0);
      end else
         check(32'(write_enable_latch), 32'h1);
   endtask : do_erase
   // upper lines carry noise: single-line mode must ignore them
   task automatic send_bits(input logic [39:0] v, input int n);
      int j;
      link2.cs_n <= 1'b0;
      link2.host_oe <= 4'hf;
      for (j = 39; j > 39 - n; j--) begin
         link2.host_out <= {3'($random(seed)), v[j]};
         tick(8);
         link2.sclk <= 1'b1;
         tick(8);
         link2.sclk <= 1'b0;
      end
      tick(8);
      link2.cs_n <= 1'b1;
      link2.host_oe <= 4'h0;
      tick(20);
   endtask : send_bits
   // ========
   // sequence
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      int b;
      logic [27:0] sa;
      seed = 46;
      {n_fail, samples_checked} = '0;
      {rst, cmd_valid, quad_mode, ext_addr, four_byte, psel, quad_en, boot_quad} = 8'h80;
      {cmd_addr, bprot, psp, dsp, boot_delay} = '0;
      cmd_kind = KIND_STATUS;
      boot_cfg = 32'hffff_ffff;
      {link2.sclk, link2.cs_n, link2.host_out, link2.host_oe} = 10'h100;
      for (b = 0; b < 4; b++) begin
         sa = 28'($random(seed));
         rst <= 1'b1;
         boot_cfg <= {sa, 1'b1, 2'(b), 1'b0};
         quad_en <= b[0];
         boot_quad <= b[0];
         boot_delay <= 6'(7 + 2 * b);
         tick(2);
         rst <= 1'b0;
         tick(3);
         host_cmd(KIND_BOOT, 32'h0);
         check(32'(rx), 32'({sa[3:0], 4'h0} ^ 8'h5a));
      end
      for (b = 0; b < 8; b++) begin
         quad_mode <= b[0];
         ext_addr <= b[2];
         four_byte <= b[2];
         tick(1);
         do_erase(sfes_kind_t'(b % 4 + 1), $random(seed) & 32'h000e_ffff, 1'b1);
      end
      {quad_mode, ext_addr, four_byte} <= 3'b000;
      bprot <= 4'h1;
      tick(1);
      do_erase(KIND_SECTOR, 32'h000f_1234, 1'b0);
      do_erase(KIND_WHOLE, 32'h0, 1'b0);
      do_erase(KIND_FULL, 32'h000e_ffff, 1'b1);
      psel <= 1'b1;
      psp <= 16'h0001;
      dsp <= 16'h8000;
      tick(1);
      do_erase(KIND_SECTOR, 32'h0000_0fff, 1'b0);
      do_erase(KIND_HALF, 32'h0009_8000, 1'b1);
      do_erase(KIND_WHOLE, 32'h0, 1'b1);
      {psel, bprot, psp, dsp} <= '0;
      four_byte <= 1'b1;
      host_cmd(KIND_FOUR_BYTE, 32'h0);
      check(32'(fourb), 32'h1);
      do_erase(KIND_HALF, 32'h0007_ffff, 1'b1);
      // first select after reset is taken by the boot read
      send_bits(40'h0, 24);
      // well-formed erase with the latch still clear must be ignored
      send_bits({OP_SECTOR_ERASE, 32'h0001_2300}, 32);
      check(32'(busy2), 32'h0);
      check(32'(wel2), 32'h0);
      send_bits({OP_WRITE_ENABLE, 32'h0}, 8);
      send_bits({OP_SECTOR_ERASE, 32'h0001_2300}, 28);
      check(32'(busy2), 32'h0);
      check(32'(wel2), 32'h1);
      send_bits({OP_WHOLE_ARRAY_ERASE, 32'h0}, 32);
      check(32'(busy2), 32'h0);
      send_bits({OP_SECTOR_ERASE, 32'h0001_2300}, 32);
      check(32'(busy2), 32'h1);
      close_out();
   end
endmodule : tb_top
